// ==== core/charge_termination_monitor.sv ====
// termination selection, hot battery and battery removal monitor with apb registers
`timescale 1ns/1ps
`default_nettype none
module charge_termination_monitor #(
  parameter int unsigned MR_HOLD_CYCLES = 32'(ctm_pkg::MR_CYCLES)
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output var  logic [31:0]                  prdata_reg,
  output var  logic                         pready_reg,
  output var  logic                         pslverr_reg,
  input  wire logic                         master_reset_low_input,
  input  wire logic [1:0]                   termination_select,
  input  wire logic                         cell_above_reference,
  input  wire logic                         charge_on,
  input  wire logic                         sample_valid,
  input  wire logic [ctm_pkg::SAMPLE_W-1:0] temp_sense_input,
  output var  ctm_pkg::term_en_t            term_en_reg,
  output var  logic                         fast_charge_end_reg,
  output var  logic                         hot_shutdown_reg,
  output var  logic                         polling_mode_reg,
  output var  logic                         irq_reg
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [12:0] slope_threshold(input logic [1:0] rate);
    logic [12:0] thr;
    thr = ctm_pkg::THR_SLOW_MV;
    if (rate == ctm_pkg::RATE_FAST) begin
      thr = ctm_pkg::THR_FAST_MV;
    end else if (rate == ctm_pkg::RATE_MID) begin
      thr = ctm_pkg::THR_MID_MV;
    end
    return thr;
  endfunction : slope_threshold

  function automatic ctm_pkg::term_en_t decode_select(input logic [1:0] code);
    ctm_pkg::term_en_t en;
    en = '{volt: 1'b1, temp: 1'b0, maxtemp: 1'b0, timer: 1'b0};  // low, open or illegal
    if (code == ctm_pkg::TSEL_HIGH) begin
      en = '{volt: 1'b1, temp: 1'b1, maxtemp: 1'b1, timer: 1'b1};
    end else if (code == ctm_pkg::TSEL_IND) begin
      en = '{volt: 1'b0, temp: 1'b1, maxtemp: 1'b1, timer: 1'b1};
    end
    return en;
  endfunction : decode_select

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       mr_low_sync;
  logic       above_sync;
  logic [1:0] tsel_sync;

  // first stage feeds the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 4'hf;
      sync2_reg <= 4'hf;
    end else begin
      sync1_reg <= {master_reset_low_input, cell_above_reference, termination_select};
      sync2_reg <= sync1_reg;
    end
  end
  assign mr_low_sync = !sync2_reg[3];
  assign above_sync  = sync2_reg[2];
  assign tsel_sync   = sync2_reg[1:0];

  // ----------------------------------------------------------------------
  // master reset qualifier
  // ----------------------------------------------------------------------
  logic [ctm_pkg::MR_CNT_W-1:0] mr_cnt_reg;
  logic [ctm_pkg::MR_CNT_W-1:0] mr_cnt_next;
  logic                         mr_active_reg;
  logic                         mr_active_next;
  logic [ctm_pkg::MR_CNT_W-1:0] mr_hold;

  assign mr_hold = ctm_pkg::MR_CNT_W'(MR_HOLD_CYCLES);

  // short glitches on the pin never reach the monitor; a long low holds it
  always_comb begin
    mr_cnt_next    = '0;
    mr_active_next = 1'b0;
    if (mr_low_sync) begin
      mr_cnt_next    = (mr_cnt_reg == mr_hold) ? mr_cnt_reg : mr_cnt_reg + 1'b1;  // see R10
      mr_active_next = (mr_cnt_reg == mr_hold);                                    // see R10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr_cnt_reg    <= '0;
      mr_active_reg <= 1'b0;
    end else begin
      mr_cnt_reg    <= mr_cnt_next;
      mr_active_reg <= mr_active_next;
    end
  end

  // ----------------------------------------------------------------------
  // monitor state, slope window and status outputs
  // ----------------------------------------------------------------------
  ctm_pkg::mon_state_t           state_reg, state_next;
  ctm_pkg::term_en_t             term_en_next;
  ctm_pkg::ctrl_t                ctrl_reg, ctrl_next;
  logic [1:0]                    boot_reg, boot_next;
  logic [ctm_pkg::WIN_AW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [4:0]                    fill_reg, fill_next;
  logic                          pend_reg, pend_next;
  logic                          pend_full_reg, pend_full_next;
  logic [ctm_pkg::SAMPLE_W-1:0]  newest_reg, newest_next;
  logic [ctm_pkg::SAMPLE_W-1:0]  slope_reg, slope_next;
  logic [ctm_pkg::SAMPLE_W-1:0]  oldest;
  logic [ctm_pkg::SAMPLE_W-1:0]  slope_now;
  logic [ctm_pkg::IRQ_W-1:0]     ev;
  logic                          capture;
  logic                          take_sample;
  logic                          hot_now;

  sample_mem u_mem (
    .pclk      (pclk),
    .we        (take_sample),
    .addr      (wr_ptr_reg),
    .wdata     (temp_sense_input),
    .rdata_reg (oldest)
  );

  assign capture     = (state_reg == ctm_pkg::ST_RESET_HOLD) && !mr_active_reg && (boot_reg == 2'h0);
  assign take_sample = sample_valid && (state_reg == ctm_pkg::ST_NORMAL);
  // only a drop counts: an ntc reads lower as the pack heats
  assign slope_now   = (oldest > newest_reg) ? oldest - newest_reg : '0;
  // open switch or hot thermistor; a closed switch below its limit is plain normal charging
  assign hot_now     = sample_valid && (ctrl_reg.sensor_switch ?
                       (temp_sense_input > ctm_pkg::SW_OPEN_MV) :    // see R02 R03
                       (temp_sense_input < ctm_pkg::THM_HOT_MV));     // see R09

  always_comb begin
    state_next     = state_reg;
    term_en_next   = term_en_reg;
    boot_next      = (boot_reg == 2'h0) ? boot_reg : boot_reg - 1'b1;
    wr_ptr_next    = wr_ptr_reg;
    fill_next      = fill_reg;
    pend_next      = 1'b0;
    pend_full_next = pend_full_reg;
    newest_next    = newest_reg;
    slope_next     = slope_reg;
    ev             = '0;
    if (capture) begin
      term_en_next = decode_select(tsel_sync);  // see R04 R05 R06
      state_next   = ctm_pkg::ST_NORMAL;
      wr_ptr_next  = '0;
      fill_next    = '0;
    end
    if (take_sample) begin
      wr_ptr_next    = wr_ptr_reg + 1'b1;  // see R11
      fill_next      = (fill_reg == ctm_pkg::WIN_DEPTH) ? fill_reg : fill_reg + 1'b1;
      pend_next      = 1'b1;
      pend_full_next = (fill_reg == ctm_pkg::WIN_DEPTH);
      newest_next    = temp_sense_input;
    end
    // one comparison per sample, against the entry a full minute old
    if (pend_reg && pend_full_reg) begin
      slope_next = slope_now;
      if (term_en_reg.temp && state_reg == ctm_pkg::ST_NORMAL &&
          slope_now >= slope_threshold(ctrl_reg.rate_class)) begin  // see R01 R11
        state_next         = ctm_pkg::ST_TERMINATED;
        ev[ctm_pkg::IRQ_SLOPE] = 1'b1;
      end
    end
    // comparator is only meaningful while current flows
    if (charge_on && (state_reg == ctm_pkg::ST_NORMAL || state_reg == ctm_pkg::ST_TERMINATED) &&
        above_sync) begin  // see R07 R08
      state_next               = ctm_pkg::ST_POLL;
      ev[ctm_pkg::IRQ_REMOVED] = 1'b1;
    end else if (charge_on && state_reg == ctm_pkg::ST_POLL && !above_sync) begin  // see R07
      state_next                = ctm_pkg::ST_NORMAL;
      fill_next                 = '0;
      ev[ctm_pkg::IRQ_DETECTED] = 1'b1;
    end
    // hot shutdown outranks everything but master reset and is left only by reset
    if (hot_now && state_reg != ctm_pkg::ST_RESET_HOLD && state_reg != ctm_pkg::ST_SHUTDOWN) begin
      state_next           = ctm_pkg::ST_SHUTDOWN;  // see R02 R09
      ev[ctm_pkg::IRQ_HOT] = 1'b1;
    end
    if (mr_active_reg) begin
      state_next = ctm_pkg::ST_RESET_HOLD;  // see R10
      ev         = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg           <= ctm_pkg::ST_RESET_HOLD;
      term_en_reg         <= '{volt: 1'b1, temp: 1'b0, maxtemp: 1'b0, timer: 1'b0};
      boot_reg            <= ctm_pkg::BOOT_WAIT;
      wr_ptr_reg          <= '0;
      fill_reg            <= '0;
      pend_reg            <= 1'b0;
      pend_full_reg       <= 1'b0;
      newest_reg          <= '0;
      slope_reg           <= '0;
      fast_charge_end_reg <= 1'b0;
      hot_shutdown_reg    <= 1'b0;
      polling_mode_reg    <= 1'b0;
    end else begin
      state_reg           <= state_next;
      term_en_reg         <= term_en_next;
      boot_reg            <= boot_next;
      wr_ptr_reg          <= wr_ptr_next;
      fill_reg            <= fill_next;
      pend_reg            <= pend_next;
      pend_full_reg       <= pend_full_next;
      newest_reg          <= newest_next;
      slope_reg           <= slope_next;
      fast_charge_end_reg <= (state_next == ctm_pkg::ST_TERMINATED);
      hot_shutdown_reg    <= (state_next == ctm_pkg::ST_SHUTDOWN);
      polling_mode_reg    <= (state_next == ctm_pkg::ST_POLL);
    end
  end

  // ----------------------------------------------------------------------
  // apb slave and interrupt registers
  // ----------------------------------------------------------------------
  logic [ctm_pkg::IRQ_W-1:0] stat_reg, stat_next;
  logic [ctm_pkg::IRQ_W-1:0] mask_reg, mask_next;
  logic [31:0]               prdata_next;
  logic                      pslverr_next;
  logic                      wr_acc;
  logic                      mapped;

  assign wr_acc = psel && penable && pready_reg && pwrite;
  assign mapped = (paddr == ctm_pkg::OFF_CTRL) || (paddr == ctm_pkg::OFF_STATUS) ||
                  (paddr == ctm_pkg::OFF_IRQ_STAT) || (paddr == ctm_pkg::OFF_IRQ_MASK) ||
                  (paddr == ctm_pkg::OFF_SLOPE);

  // answer is prepared in the setup cycle so pready can come from a flop with no wait state
  always_comb begin
    ctrl_next    = ctrl_reg;
    mask_next    = mask_reg;
    stat_next    = stat_reg;
    prdata_next  = '0;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      pslverr_next = !mapped;
      unique case (paddr)
        ctm_pkg::OFF_CTRL:     prdata_next = {29'h0, ctrl_reg};
        ctm_pkg::OFF_STATUS:   prdata_next = {23'h0, mr_active_reg, (fill_reg == ctm_pkg::WIN_DEPTH),
                                              term_en_reg, state_reg};
        ctm_pkg::OFF_IRQ_STAT: prdata_next = {28'h0, stat_reg};
        ctm_pkg::OFF_IRQ_MASK: prdata_next = {28'h0, mask_reg};
        ctm_pkg::OFF_SLOPE:    prdata_next = {19'h0, slope_reg};
        default:               prdata_next = '0;
      endcase
    end
    if (wr_acc && paddr == ctm_pkg::OFF_CTRL) begin
      ctrl_next = pwdata[2:0];
    end
    if (wr_acc && paddr == ctm_pkg::OFF_IRQ_MASK) begin
      mask_next = pwdata[ctm_pkg::IRQ_W-1:0];
    end
    if (wr_acc && paddr == ctm_pkg::OFF_IRQ_STAT) begin
      stat_next = stat_reg & ~pwdata[ctm_pkg::IRQ_W-1:0];
    end
    stat_next = stat_next | ev;  // a new event beats a clear in the same cycle
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= ctm_pkg::CTRL_RESET;
      mask_reg    <= '0;
      stat_reg    <= '0;
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      mask_reg    <= mask_next;
      stat_reg    <= stat_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= psel && !penable;
      pslverr_reg <= pslverr_next;
      irq_reg     <= |(stat_next & mask_next);
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_slope_term;
    @(posedge pclk) disable iff (!presetn)
    (pend_reg && pend_full_reg && term_en_reg.temp && state_reg == ctm_pkg::ST_NORMAL && !mr_active_reg &&
     !hot_now && !(charge_on && above_sync) && slope_now >= slope_threshold(ctrl_reg.rate_class))
    |=> state_reg == ctm_pkg::ST_TERMINATED ##0 fast_charge_end_reg;
  endproperty
  a_slope_term: assert property (p_slope_term) else $error("slope over threshold did not end fast charge"); // see R01

  property p_switch_open;
    @(posedge pclk) disable iff (!presetn)
    (sample_valid && ctrl_reg.sensor_switch && temp_sense_input > ctm_pkg::SW_OPEN_MV &&
     state_reg != ctm_pkg::ST_RESET_HOLD && !mr_active_reg)
    |=> hot_shutdown_reg ##1 (hot_shutdown_reg || mr_active_reg);
  endproperty
  a_switch_open: assert property (p_switch_open) else $error("open switch did not shut down"); // see R02

  property p_switch_closed;
    @(posedge pclk) disable iff (!presetn)
    (sample_valid && ctrl_reg.sensor_switch && temp_sense_input < ctm_pkg::SW_CLOSED_MV &&
     state_reg == ctm_pkg::ST_NORMAL) |=> !hot_shutdown_reg;
  endproperty
  a_switch_closed: assert property (p_switch_closed) else $error("closed switch caused a shutdown"); // see R03

  property p_select_decode;
    @(posedge pclk) disable iff (!presetn)
    capture |=> term_en_reg == decode_select($past(tsel_sync)) && term_en_reg.volt == ($past(tsel_sync) != ctm_pkg::TSEL_IND);
  endproperty
  a_select_decode: assert property (p_select_decode) else $error("termination select decoded wrongly"); // see R04

  property p_select_frozen;
    @(posedge pclk) disable iff (!presetn)
    !capture |=> $stable(term_en_reg);
  endproperty
  a_select_frozen: assert property (p_select_frozen) else $error("termination method changed without reset"); // see R05

  property p_temp_keeps_others;
    @(posedge pclk) disable iff (!presetn)
    term_en_reg.temp |-> term_en_reg.maxtemp && term_en_reg.timer;
  endproperty
  a_temp_keeps_others: assert property (p_temp_keeps_others) else $error("max temp or timer off with temp slope"); // see R06

  property p_poll_needs_current;
    @(posedge pclk) disable iff (!presetn)
    $rose(polling_mode_reg) |-> $past(charge_on) && $past(above_sync);
  endproperty
  a_poll_needs_current: assert property (p_poll_needs_current) else $error("polling entered without current on"); // see R07

  property p_removed_polls;
    @(posedge pclk) disable iff (!presetn)
    (charge_on && above_sync && state_reg == ctm_pkg::ST_NORMAL && !hot_now && !mr_active_reg)
    |=> polling_mode_reg && stat_reg[ctm_pkg::IRQ_REMOVED];
  endproperty
  a_removed_polls: assert property (p_removed_polls) else $error("battery removal not detected"); // see R08

  property p_thermistor_hot;
    @(posedge pclk) disable iff (!presetn)
    (sample_valid && !ctrl_reg.sensor_switch && temp_sense_input < ctm_pkg::THM_HOT_MV &&
     state_reg != ctm_pkg::ST_RESET_HOLD && !mr_active_reg) |=> hot_shutdown_reg && stat_reg[ctm_pkg::IRQ_HOT];
  endproperty
  a_thermistor_hot: assert property (p_thermistor_hot) else $error("hot thermistor did not shut down"); // see R09

  property p_reset_hold;
    @(posedge pclk) disable iff (!presetn)
    $rose(mr_active_reg) |-> $past(mr_cnt_reg) == mr_hold && $past(mr_low_sync) ##1 state_reg == ctm_pkg::ST_RESET_HOLD;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("master reset acted on a short low"); // see R10

  property p_one_compare_per_sample;
    @(posedge pclk) disable iff (!presetn)
    pend_reg |-> $past(take_sample);
  endproperty
  a_one_compare_per_sample: assert property (p_one_compare_per_sample) else $error("compare without a sample"); // see R11

  c_slope_term: cover property (@(posedge pclk) disable iff (!presetn) $rose(fast_charge_end_reg));
  c_hot:        cover property (@(posedge pclk) disable iff (!presetn) $rose(hot_shutdown_reg));
  c_poll:       cover property (@(posedge pclk) disable iff (!presetn) $rose(polling_mode_reg));
  c_mreset:     cover property (@(posedge pclk) disable iff (!presetn) $fell(mr_active_reg));

endmodule : charge_termination_monitor
`default_nettype wire

// ==== core/ctm_pkg.sv ====
// constants, types and register map of the charge termination monitor
// What this block does
// R01: with temperature slope active, fast charge ends once the thermistor voltage falls 40, 28 or 18 mV per minute by rate.
// R02: with a thermal switch, a sense level above 4.2 V means a hot battery and charging shuts down until master reset.
// R03: with a thermal switch, a sense level below 0.5 V means a cool battery and charging carries on normally.
// R04: the termination select pin picks voltage slope (low), both slopes (high) or temperature slope (tied to indicator).
// R05: the termination select setting is sampled only at reset and a new setting needs a master reset.
// R06: whenever temperature slope is selected, maximum temperature and fast charge timer termination stay enabled.
// R07: the cell voltage versus open circuit reference comparison counts only while the charge output is on.
// R08: a cell voltage above the open circuit reference means the battery is gone and the block enters polling.
// R09: with a thermistor, a sense level below 0.93 V is a hot fault and charging shuts down until master reset.
// R10: master reset acts only after its low input is held more than 700 ms, and holds as long as it stays low.
// R11: the temperature slope is the drop across a sliding one-minute window of samples, checked once per sample.
package ctm_pkg;

  // ----------------------------------------------------------------------
  // monitor states and decoded pin codes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET_HOLD = 3'b000,
    ST_NORMAL     = 3'b001,
    ST_TERMINATED = 3'b010,
    ST_POLL       = 3'b011,
    ST_SHUTDOWN   = 3'b100
  } mon_state_t;

  // code from the three-level pad detector of the select pin
  localparam logic [1:0] TSEL_LOW  = 2'h0;
  localparam logic [1:0] TSEL_HIGH = 2'h1;
  localparam logic [1:0] TSEL_IND  = 2'h2;

  // charge rate classes written by software
  localparam logic [1:0] RATE_FAST = 2'h0;  // faster than C/2
  localparam logic [1:0] RATE_MID  = 2'h1;  // C/2 through C/3

  typedef struct packed {
    logic volt;
    logic temp;
    logic maxtemp;
    logic timer;
  } term_en_t;

  typedef struct packed {
    logic [1:0] rate_class;
    logic       sensor_switch;
  } ctrl_t;

  // ----------------------------------------------------------------------
  // sample window in bits and entries, thresholds in millivolts
  // ----------------------------------------------------------------------
  localparam int         SAMPLE_W      = 13;
  localparam int         WIN_AW        = 4;
  localparam logic [4:0] WIN_DEPTH     = 5'h10;
  localparam logic [12:0] THR_FAST_MV  = 13'h0028;  // 40 mV
  localparam logic [12:0] THR_MID_MV   = 13'h001c;  // 28 mV
  localparam logic [12:0] THR_SLOW_MV  = 13'h0012;  // 18 mV
  localparam logic [12:0] SW_OPEN_MV   = 13'h1068;  // 4.2 V
  localparam logic [12:0] SW_CLOSED_MV = 13'h01f4;  // 0.5 V
  localparam logic [12:0] THM_HOT_MV   = 13'h03a2;  // 0.93 V

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam longint unsigned CLK_HZ     = 64'd10_000_000;
  localparam longint unsigned MR_TIME_MS = 64'd700;
  localparam longint unsigned MR_CYCLES  = MR_TIME_MS * CLK_HZ / 64'd1000;
  localparam int              MR_CNT_W   = 24;
  localparam logic [1:0]      BOOT_WAIT  = 2'h2;    // lets the pin synchroniser settle

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_SLOPE    = 8'h10;
  localparam int         IRQ_W        = 4;
  localparam int         IRQ_SLOPE    = 0;
  localparam int         IRQ_HOT      = 1;
  localparam int         IRQ_REMOVED  = 2;
  localparam int         IRQ_DETECTED = 3;
  localparam logic [2:0] CTRL_RESET   = 3'h0;

endpackage : ctm_pkg

// ==== core/sample_mem.sv ====
// small sample store of the slope window, read-before-write, registered read
`timescale 1ns/1ps
`default_nettype none
module sample_mem (
  input  wire logic                          pclk,
  input  wire logic                          we,
  input  wire logic [ctm_pkg::WIN_AW-1:0]    addr,
  input  wire logic [ctm_pkg::SAMPLE_W-1:0]  wdata,
  output var  logic [ctm_pkg::SAMPLE_W-1:0]  rdata_reg
);

  logic [ctm_pkg::SAMPLE_W-1:0] mem [0:(1<<ctm_pkg::WIN_AW)-1];

  // old contents come out while the new sample goes in, so the oldest entry is seen once
  always_ff @(posedge pclk) begin
    rdata_reg <= mem[addr];
    if (we) begin
      mem[addr] <= wdata;
    end
  end

endmodule : sample_mem
`default_nettype wire

// ==== verif/battery_pack.sv ====
// battery pack model: thermistor samples and open circuit comparator
`timescale 1ns/1ps
`default_nettype none
module battery_pack (
  input  wire logic        pclk,
  input  wire logic        charge_on,
  input  wire logic        present,
  input  wire logic        take,
  input  wire logic [12:0] mv,
  output var  logic        sample_valid,
  output var  logic [12:0] temp_sense_input,
  output var  logic        cell_above_reference
);
  logic flip;
  initial begin
    flip = 1'b0;
    sample_valid = 1'b0;
    temp_sense_input = 13'h0;
  end
  // with the source off the comparator means nothing, so it wanders
  always @(posedge pclk) begin
    flip <= ~flip;
    sample_valid <= take;
    temp_sense_input <= take ? mv : ~temp_sense_input;  // stale value is not held
    cell_above_reference <= charge_on ? ~present : flip;
  end
endmodule : battery_pack
`default_nettype wire

// ==== verif/charge_termination_monitor_tb.sv ====
// self-checking bench of the charge termination monitor
`timescale 1ns/1ps
`default_nettype none
module charge_termination_monitor_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mr_n = 1, chg = 1, present = 1, take = 0;
  logic [11:0] note;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata_reg, xs = 32'h2732;
  logic [1:0] tsel = 0;
  logic [12:0] mv = 0, tsi, base;
  logic pready_reg, pslverr_reg, above, sv, fce, hot, pol, irq;
  ctm_pkg::term_en_t ten;
  logic [11:0] exp_q[$];
  int mismatches = 0, total_checks = 0, cyc = 0;
  logic [1:0] sels[3] = '{ctm_pkg::TSEL_LOW, ctm_pkg::TSEL_IND, ctm_pkg::TSEL_HIGH};
  logic [3:0] ens[3] = '{4'h8, 4'h7, 4'hf};
  logic [12:0] thr[3] = '{13'h0028, 13'h001c, 13'h0012};
  always #50 pclk = ~pclk;
  charge_termination_monitor #(.MR_HOLD_CYCLES(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_reg(prdata_reg),
    .pready_reg(pready_reg), .pslverr_reg(pslverr_reg), .master_reset_low_input(mr_n), .termination_select(tsel),
    .cell_above_reference(above), .charge_on(chg), .sample_valid(sv), .temp_sense_input(tsi),
    .term_en_reg(ten), .fast_charge_end_reg(fce), .hot_shutdown_reg(hot), .polling_mode_reg(pol), .irq_reg(irq));
  battery_pack pack_u (.pclk(pclk), .charge_on(chg), .present(present), .take(take), .mv(mv),
    .sample_valid(sv), .temp_sense_input(tsi), .cell_above_reference(above));
  // ----------------------------------------------------------------------
  // bus, sample and reset tasks
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    xs ^= xs << 13;
    xs ^= xs >> 17;
    xs ^= xs << 5;
    return xs;
  endfunction : rnd
  task automatic check(input logic [11:0] seen, input logic [11:0] e);
    total_checks++;
    if (seen !== e) begin
      mismatches++;
      $display("BAD %0t %h %h", $time, seen, e);
    end
  endtask : check
  task automatic end_sim();
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // one idle edge first, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready_reg !== 1'b1);
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [11:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic smp(input logic [12:0] v);
    take <= 1; mv <= v;
    @(posedge pclk);
    take <= 0;
    repeat (2) @(posedge pclk);
  endtask : smp
  task automatic mres(input int n);
    mr_n <= 0;
    repeat (n) @(posedge pclk);
    mr_n <= 1;
    repeat (6) @(posedge pclk);
  endtask : mres
  // read results are noted as {err,irq,poll,hot,end,data[6:0]}
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready_reg === 1'b1 && !pwrite && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check({pslverr_reg, irq, pol, hot, fce, prdata_reg[6:0]}, note);
      // the enable pins must agree with the noted status field
      if (paddr == ctm_pkg::OFF_STATUS) check({8'h0, ten}, {8'h0, note[6:3]});
    end
    if (cyc == 8000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    for (int i = 0; i < 3; i++) begin
      tsel <= sels[i]; presetn <= 0;
      repeat (12) @(posedge pclk);
      presetn <= 1;
      repeat (6) @(posedge pclk);
      rd(ctm_pkg::OFF_STATUS, {5'h0, ens[i], 3'h1});
    end
    apb(1'b1, ctm_pkg::OFF_IRQ_MASK, 32'hf);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ctm_pkg::OFF_CTRL, {29'h0, 2'(i), 1'b0});
      base = 13'd1500 + 13'(rnd() & 32'h3ff);
      repeat (16) smp(base);
      smp(base - thr[i] + 13'h1);
      rd(ctm_pkg::OFF_STATUS, {5'h0, 4'hf, 3'h1});
      smp(base - thr[i]);
      rd(ctm_pkg::OFF_STATUS, {5'h09, 4'hf, 3'h2});
      rd(ctm_pkg::OFF_SLOPE, {5'h09, thr[i][6:0]});
      apb(1'b1, ctm_pkg::OFF_IRQ_STAT, 32'h1);
      mres(30);
    end
    smp(13'd930);
    rd(ctm_pkg::OFF_STATUS, {5'h0, 4'hf, 3'h1});
    smp(13'd929);
    rd(ctm_pkg::OFF_STATUS, {5'h0a, 4'hf, 3'h4});
    mres(15);
    rd(ctm_pkg::OFF_STATUS, {5'h0a, 4'hf, 3'h4});
    mres(30);
    apb(1'b1, ctm_pkg::OFF_IRQ_STAT, 32'h2);
    rd(ctm_pkg::OFF_STATUS, {5'h0, 4'hf, 3'h1});
    apb(1'b1, ctm_pkg::OFF_CTRL, 32'h1);
    smp(13'd929);
    smp(13'd4200);
    smp(13'd400);
    rd(ctm_pkg::OFF_STATUS, {5'h0, 4'hf, 3'h1});
    smp(13'd4201);
    rd(ctm_pkg::OFF_STATUS, {5'h0a, 4'hf, 3'h4});
    apb(1'b1, ctm_pkg::OFF_IRQ_STAT, 32'h2);
    mres(30);
    chg <= 0; present <= 0;
    repeat (10) @(posedge pclk);
    rd(ctm_pkg::OFF_STATUS, {5'h0, 4'hf, 3'h1});
    chg <= 1;
    repeat (6) @(posedge pclk);
    rd(ctm_pkg::OFF_STATUS, {5'h0c, 4'hf, 3'h3});
    present <= 1;
    repeat (6) @(posedge pclk);
    rd(ctm_pkg::OFF_IRQ_STAT, {5'h08, 7'h0c});
    rd(8'h14, {5'h18, 7'h0});
    tsel <= ctm_pkg::TSEL_LOW;
    repeat (6) @(posedge pclk);
    rd(ctm_pkg::OFF_STATUS, {5'h08, 4'hf, 3'h1});
    mres(30);
    rd(ctm_pkg::OFF_STATUS, {5'h08, 4'h8, 3'h1});
    end_sim();
  end
endmodule : charge_termination_monitor_tb
`default_nettype wire
